// file: core/tas_cfg.svh
// register offsets, field positions and reset values of the thermal alarm block
`ifndef TAS_CFG_SVH
`define TAS_CFG_SVH
`define TAS_OFS_R1_CFG     8'h5f
`define TAS_OFS_LOC_CFG    8'h60
`define TAS_OFS_R2_CFG     8'h61
`define TAS_OFS_ACOUSTIC   8'h62
`define TAS_OFS_R1_CRIT    8'h6a
`define TAS_OFS_LOC_CRIT   8'h6b
`define TAS_OFS_R2_CRIT    8'h6c
`define TAS_OFS_MASK2      8'h75
`define TAS_OFS_STATUS2    8'h42
`define TAS_OFS_CONFIG3    8'h78
`define TAS_OFS_TIME_LIM   8'h7a
`define TAS_BIT_ALARM_EN   3
`define TAS_BIT_SYNC       4
`define TAS_BIT_TIME_MASK  5
`define TAS_BIT_TIME_FLAG  5
`define TAS_BIT_MON_EN     1
`define TAS_RST_BYTE       8'h00
`define TAS_RST_CRIT       8'h64
`endif

// file: core/tas_pkg.sv
// types shared by the thermal alarm block
package tas_pkg;
   typedef logic [7:0] tas_byte_t;
   typedef enum logic [1:0] {
      TAS_SYNC_1 = 2'h1,
      TAS_SYNC_2 = 2'h2
   } tas_sync_e;
   typedef enum logic [1:0] {
      TAS_PIN_FREE = 2'h1,
      TAS_PIN_LOW  = 2'h2
   } tas_pin_e;
endpackage : tas_pkg

// file: core/tas_thermal_alarm.sv
// thermal alarm pin, alarm-time alert gating and tachometer to drive mapping
//
// What this block does
// - bit 5 of the second mask register set blocks the alert for an exceeded alarm-time limit.
// - an alarm-time limit of zero raises the alert on the first assertion of the alarm input.
// - the alarm pin is driven low when a temperature exceeds its critical limit by a quarter degree.
// - the pin stays low while the temperature is still above the limit at the next monitoring cycle.
// - the pin is released only once the temperature is at or below the limit.
// - once asserted the pin stays low for at least one whole monitoring cycle.
// - remote 1, local and remote 2 have own critical limits at 0x6a, 0x6b and 0x6c.
// - bit 3 of each channel configuration register enables that channel to drive the pin.
// - four tachometer inputs share three drive outputs.
// - by default tach 1 follows drive 1 and tach 3 and 4 follow drive 3.
// - with the grouping bit set tach 2, 3 and 4 all follow drive 2.
// - alarm-input monitoring works only while its enable bit in the third configuration register is set.
// - an accumulated time above the limit sets the status flag and the alert unless masked.
`timescale 1ns/1ps
`default_nettype none
`include "tas_cfg.svh"
module tas_thermal_alarm
   import tas_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  reg_rdata,
   input  wire logic        monitor_tick,
   input  wire logic [9:0]  temp_remote1,
   input  wire logic [9:0]  temp_local,
   input  wire logic [9:0]  temp_remote2,
   input  wire logic [7:0]  alarm_timer,
   input  wire logic        alarm_pin_i,
   output logic             alarm_pin_o,
   output logic             alarm_pin_oe,
   output logic             alert_b,
   input  wire logic        fan_speed_in_1,
   input  wire logic        fan_speed_in_2,
   input  wire logic        fan_speed_in_3,
   input  wire logic        fan_speed_in_4,
   output logic      [3:0]  tach_sync_sel_2,
   output logic             alarm_asserted,
   output logic      [3:0]  fan_speed_sync
);
   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      tas_byte_t [2:0] chan_cfg;
      tas_byte_t       acoustic;
      tas_byte_t [2:0] crit;
      tas_byte_t       mask2;
      tas_byte_t       config3;
      tas_byte_t       time_lim;
      logic            time_flag;
      tas_pin_e        pin;
      logic            held;
      logic      [1:0] chk_ticks;
      logic      [3:0] own_s;
      logic      [1:0] ain_s1;
      logic      [1:0] ain_s2;
      logic      [3:0] tach_s1;
      logic      [3:0] tach_s2;
      tas_byte_t       rdata;
   } tas_state_s;

   tas_state_s st_r;
   tas_state_s st_nxt;

   // temperature in quarter degrees above limit in whole degrees
   function automatic logic over_limit(input logic [9:0] t, input tas_byte_t lim);
      over_limit = t > {lim, 2'b00};
   endfunction : over_limit

   logic [2:0] over;
   logic       any_trip;
   logic       ain_active;

   always_comb
   begin
      over[0] = over_limit(temp_remote1, st_r.crit[0]) && st_r.chan_cfg[0][`TAS_BIT_ALARM_EN];
      over[1] = over_limit(temp_local, st_r.crit[1]) && st_r.chan_cfg[1][`TAS_BIT_ALARM_EN];
      over[2] = over_limit(temp_remote2, st_r.crit[2]) && st_r.chan_cfg[2][`TAS_BIT_ALARM_EN];
      any_trip = |over;
      // own drive is not counted as an external alarm assertion; own_s spans the
      // synchroniser latency so the tail of a self-driven low is not taken as an input
      ain_active = st_r.config3[`TAS_BIT_MON_EN] && !st_r.ain_s2[1]
                   && st_r.pin != TAS_PIN_LOW && !(|st_r.own_s);
   end

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.ain_s1 = {st_r.ain_s1[0], alarm_pin_i};
      st_nxt.ain_s2 = {st_r.ain_s2[0], st_r.ain_s1[1]};
      st_nxt.tach_s1 = {fan_speed_in_4, fan_speed_in_3, fan_speed_in_2, fan_speed_in_1};
      st_nxt.tach_s2 = st_r.tach_s1;
      st_nxt.own_s = {st_r.own_s[2:0], st_r.pin == TAS_PIN_LOW};
      // ****************************************************************
      // alarm pin
      // ****************************************************************
      if (monitor_tick)
      begin
         case (st_r.pin)
            TAS_PIN_FREE:
            begin
               if (any_trip)
               begin
                  st_nxt.pin = TAS_PIN_LOW;
                  st_nxt.held = 1'b0;
               end
            end
            TAS_PIN_LOW:
            begin
               st_nxt.held = 1'b1;
               // release needs a full cycle elapsed and no channel still over
               if (st_r.held && !any_trip)
                  st_nxt.pin = TAS_PIN_FREE;
            end
            default:
               st_nxt.pin = TAS_PIN_FREE;
         endcase
      end
      // ****************************************************************
      // alarm-time flag
      // ****************************************************************
      // monitoring ticks seen while low, read only by the hold check
      if (st_r.pin != TAS_PIN_LOW)
         st_nxt.chk_ticks = 2'h0;
      else if (monitor_tick && st_r.chk_ticks != 2'h3)
         st_nxt.chk_ticks = st_r.chk_ticks + 2'h1;
      if (reg_rd && reg_addr == `TAS_OFS_STATUS2)
         st_nxt.time_flag = 1'b0;
      if (st_r.config3[`TAS_BIT_MON_EN] &&
          ((alarm_timer > st_r.time_lim) || (st_r.time_lim == `TAS_RST_BYTE && ain_active)))
         st_nxt.time_flag = 1'b1;
      // ****************************************************************
      // register access
      // ****************************************************************
      if (reg_wr)
      begin
         case (reg_addr)
            `TAS_OFS_R1_CFG:   st_nxt.chan_cfg[0] = reg_wdata;
            `TAS_OFS_LOC_CFG:  st_nxt.chan_cfg[1] = reg_wdata;
            `TAS_OFS_R2_CFG:   st_nxt.chan_cfg[2] = reg_wdata;
            `TAS_OFS_ACOUSTIC: st_nxt.acoustic = reg_wdata;
            `TAS_OFS_R1_CRIT:  st_nxt.crit[0] = reg_wdata;
            `TAS_OFS_LOC_CRIT: st_nxt.crit[1] = reg_wdata;
            `TAS_OFS_R2_CRIT:  st_nxt.crit[2] = reg_wdata;
            `TAS_OFS_MASK2:    st_nxt.mask2 = reg_wdata;
            `TAS_OFS_CONFIG3:  st_nxt.config3 = reg_wdata;
            `TAS_OFS_TIME_LIM: st_nxt.time_lim = reg_wdata;
            default:           st_nxt.rdata = st_r.rdata;
         endcase
      end
      case (reg_addr)
         `TAS_OFS_R1_CFG:   st_nxt.rdata = st_r.chan_cfg[0];
         `TAS_OFS_LOC_CFG:  st_nxt.rdata = st_r.chan_cfg[1];
         `TAS_OFS_R2_CFG:   st_nxt.rdata = st_r.chan_cfg[2];
         `TAS_OFS_ACOUSTIC: st_nxt.rdata = st_r.acoustic;
         `TAS_OFS_R1_CRIT:  st_nxt.rdata = st_r.crit[0];
         `TAS_OFS_LOC_CRIT: st_nxt.rdata = st_r.crit[1];
         `TAS_OFS_R2_CRIT:  st_nxt.rdata = st_r.crit[2];
         `TAS_OFS_MASK2:    st_nxt.rdata = st_r.mask2;
         `TAS_OFS_CONFIG3:  st_nxt.rdata = st_r.config3;
         `TAS_OFS_TIME_LIM: st_nxt.rdata = st_r.time_lim;
         `TAS_OFS_STATUS2:  st_nxt.rdata = {2'h0, st_r.time_flag, 5'h00};
         default:           st_nxt.rdata = `TAS_RST_BYTE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_r          <= '0;
         st_r.crit     <= {3{`TAS_RST_CRIT}};
         st_r.pin      <= TAS_PIN_FREE;
         st_r.ain_s1   <= 2'h3;
         st_r.ain_s2   <= 2'h3;
      end
      else
         st_r <= st_nxt;
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   tas_sync_e sync_mode;
   assign sync_mode      = st_r.acoustic[`TAS_BIT_SYNC] ? TAS_SYNC_2 : TAS_SYNC_1;
   // bit n high: tach n+1 is measured in step with drive 2, else per default grouping
   assign tach_sync_sel_2 = (sync_mode == TAS_SYNC_2) ? 4'he : 4'h2;
   assign fan_speed_sync = st_r.tach_s2;
   assign alarm_pin_o    = 1'b0;
   assign alarm_pin_oe   = (st_r.pin == TAS_PIN_LOW);
   assign alarm_asserted = alarm_pin_oe;
   assign alert_b        = !(st_r.time_flag && !st_r.mask2[`TAS_BIT_TIME_MASK]);
   assign reg_rdata      = st_r.rdata;

   // ****************************************************************
   // checks
   // ****************************************************************
   sequence s_pin_rise;
      !alarm_pin_oe ##1 alarm_pin_oe;
   endsequence
   a_pin_trip_cause: assert property (@(posedge clk) disable iff (!rst_b)
      s_pin_rise |-> $past(any_trip) && $past(monitor_tick)) else $error("pin drove without a trip");
   a_pin_hold_min: assert property (@(posedge clk) disable iff (!rst_b)
      $fell(alarm_pin_oe) |-> st_r.chk_ticks >= 2'h2) else $error("pin released early");
   a_pin_still_over: assert property (@(posedge clk) disable iff (!rst_b)
      alarm_pin_oe && monitor_tick && any_trip |=> alarm_pin_oe) else $error("pin released while over");
   a_pin_release_ok: assert property (@(posedge clk) disable iff (!rst_b)
      $fell(alarm_pin_oe) |-> !$past(any_trip)) else $error("pin released while over limit");
   a_pin_never_high: assert property (@(posedge clk) disable iff (!rst_b)
      alarm_pin_oe |-> alarm_pin_o == 1'b0) else $error("pin driven high");
   a_alert_masked: assert property (@(posedge clk) disable iff (!rst_b)
      st_r.mask2[`TAS_BIT_TIME_MASK] |-> alert_b) else $error("masked alert asserted");
   a_flag_on_limit: assert property (@(posedge clk) disable iff (!rst_b)
      st_r.config3[`TAS_BIT_MON_EN] && alarm_timer > st_r.time_lim |=> st_r.time_flag)
      else $error("flag missed");
   a_zero_limit: assert property (@(posedge clk) disable iff (!rst_b)
      ain_active && st_r.time_lim == 8'h00 |=> st_r.time_flag) else $error("zero limit missed");
   a_sync_group: assert property (@(posedge clk) disable iff (!rst_b)
      st_r.acoustic[`TAS_BIT_SYNC] |-> tach_sync_sel_2 == 4'he) else $error("sync grouping wrong");
endmodule : tas_thermal_alarm
`default_nettype wire

// file: tb/tas_far_side.sv
// far side model: pulled-up alarm wire with an outside hot source, and fan tach pulses
`timescale 1ns/1ps
`default_nettype none
module tas_far_side
(
   input  wire logic       clk,
   input  wire logic       alarm_pin_oe,
   input  wire logic       hot_req,
   output logic            alarm_pin_i,
   output logic      [3:0] fan_tach
);
   logic [7:0] div_r = 8'h00;
   // wired-and with a pull-up: either party may pull low, nobody drives high
   assign alarm_pin_i = ~(alarm_pin_oe | hot_req);
   always_ff @(posedge clk) div_r <= div_r + 8'h01;
   // four fans at different rates so the sync pipes see real edges
   assign fan_tach = {div_r[6], div_r[5], div_r[4], div_r[3]};
endmodule : tas_far_side
`default_nettype wire

// file: tb/thermal_alarm_and_tach_sync_tb_top.sv
// self-checking bench of the thermal alarm block
`timescale 1ns/1ps
`default_nettype none
module thermal_alarm_and_tach_sync_tb_top;
   import tas_pkg::*;
   logic       clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, tick = 1'b0, hot = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, timer = 8'h00;
   logic [9:0] t_r1 = 10'h000, t_lo = 10'h000, t_r2 = 10'h000;
   logic       pin_i, pin_o, pin_oe, alert_b, asserted;
   logic [3:0] tach, sel2, tsync;
   int         n_mismatch = 0, samples_checked = 0, cyc = 0;
   always #5 clk = ~clk;
   tas_far_side i_far (.clk(clk), .alarm_pin_oe(pin_oe), .hot_req(hot), .alarm_pin_i(pin_i), .fan_tach(tach));
   tas_thermal_alarm i_dut (.clk(clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(addr),
      .reg_wdata(wdata), .reg_rdata(rdata), .monitor_tick(tick), .temp_remote1(t_r1), .temp_local(t_lo),
      .temp_remote2(t_r2), .alarm_timer(timer), .alarm_pin_i(pin_i), .alarm_pin_o(pin_o),
      .alarm_pin_oe(pin_oe), .alert_b(alert_b), .fan_speed_in_1(tach[0]), .fan_speed_in_2(tach[1]),
      .fan_speed_in_3(tach[2]), .fan_speed_in_4(tach[3]), .tach_sync_sel_2(sel2),
      .alarm_asserted(asserted), .fan_speed_sync(tsync));
   // ********************
   // bus and check tasks
   // ********************
   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
      samples_checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : check_byte
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = rdata;
   endtask : rd
   // one monitoring cycle; channels other than ch get random readings
   task automatic mon(input int ch, input logic [9:0] v);
      @(posedge clk);
      t_r1 <= (ch == 0) ? v : 10'($urandom);
      t_lo <= (ch == 1) ? v : 10'($urandom);
      t_r2 <= (ch == 2) ? v : 10'($urandom);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      @(posedge clk);
      #1;
   endtask : mon
   task automatic final_report;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : final_report
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_mismatch++;
         final_report();
      end
   end
   initial
   begin
      logic [7:0] d;
      logic [7:0] lim;
      logic [9:0] thr;
      logic [3:0] t0;
      void'($urandom(32'hade2));
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      rd(8'h6c, d);
      check_byte(d, 8'h64, "crit reset");
      rd(8'h13, d);
      check_byte(d, 8'h00, "unmapped read");
      check_byte({4'h0, sel2}, 8'h02, "default sync");
      wr(8'h62, 8'h10);
      @(posedge clk);
      #1 check_byte({4'h0, sel2}, 8'h0e, "grouped sync");
      $display("test sync done");
      for (int ch = 0; ch < 3; ch++)
      begin
         lim = 8'h20 + 8'($urandom % 128);
         thr = {lim, 2'b00};
         wr(8'h6a + 8'(ch), lim);
         mon(ch, thr + 10'h001);
         check_byte({7'h0, pin_oe}, 8'h00, "disabled channel");
         wr(8'h5f + 8'(ch), 8'h08);
         mon(ch, thr);
         check_byte({7'h0, pin_oe}, 8'h00, "at limit");
         mon(ch, thr + 10'h001);
         check_byte({7'h0, pin_oe}, 8'h01, "quarter above");
         check_byte({7'h0, pin_o}, 8'h00, "pin only pulls low");
         mon(ch, thr);
         check_byte({7'h0, asserted}, 8'h01, "held a cycle");
         mon(ch, thr + 10'h001 + 10'($urandom % 64));
         check_byte({7'h0, pin_oe}, 8'h01, "still above");
         mon(ch, thr);
         check_byte({7'h0, pin_oe}, 8'h00, "released");
         wr(8'h5f + 8'(ch), 8'h00);
         $display("test channel %0d done", ch);
      end
      wr(8'h78, 8'h02);
      wr(8'h7a, 8'h00);
      wr(8'h75, 8'h20);
      @(posedge clk);
      hot <= 1'b1;
      timer <= 8'h00;
      repeat (8) @(posedge clk);
      #1 check_byte({7'h0, alert_b}, 8'h01, "masked alert");
      rd(8'h42, d);
      check_byte(d & 8'h20, 8'h20, "time flag");
      wr(8'h75, 8'h00);
      repeat (8) @(posedge clk);
      #1 check_byte({7'h0, alert_b}, 8'h00, "first assertion alert");
      timer <= 8'h03;
      wr(8'h7a, 8'h05);
      rd(8'h42, d);
      repeat (8) @(posedge clk);
      #1 check_byte({7'h0, alert_b}, 8'h01, "below time limit");
      @(posedge clk);
      timer <= 8'h06;
      repeat (3) @(posedge clk);
      #1 check_byte({7'h0, alert_b}, 8'h00, "above time limit");
      wr(8'h78, 8'h00);
      rd(8'h42, d);
      repeat (4) @(posedge clk);
      #1 check_byte({7'h0, alert_b}, 8'h01, "monitor off");
      $display("test alarm time done");
      for (int i = 0; i < 40; i++)
      begin
         @(posedge clk);
         #1 t0 = tach;
         repeat (2) @(posedge clk);
         #1 check_byte({4'h0, tsync}, {4'h0, t0}, "tach sync pipe");
      end
      $display("test tach done");
      final_report();
   end
endmodule : thermal_alarm_and_tach_sync_tb_top
`default_nettype wire
